// ===== core/rfs_consts.vh
// constants for the regulator fault status flag block
`ifndef RFS_CONSTS_VH
`define RFS_CONSTS_VH

// register indices; byte address is four times the index
`define RFS_IDX_TOP_SUMMARY      6'h19
`define RFS_IDX_CONV_INT_LATCH   6'h1b
`define RFS_IDX_LINREG_INT_LATCH 6'h1c
`define RFS_IDX_TOP_LIVE_STATUS  6'h1d
`define RFS_IDX_CONV_LIVE_STATUS 6'h1e

// latch register fields (same layout for converters and linear regulators)
`define RFS_BIT_ONE_PG    6
`define RFS_BIT_ONE_SC    5
`define RFS_BIT_ONE_ILIM  4
`define RFS_BIT_ZERO_PG   2
`define RFS_BIT_ZERO_SC   1
`define RFS_BIT_ZERO_ILIM 0
`define RFS_LATCH_MASK    8'h77
`define RFS_LATCH_RESET   8'h00

// top summary fields
`define RFS_BIT_LINREG_SUM 6
`define RFS_BIT_CONV_SUM   5

// top live status fields
`define RFS_BIT_POWER_GOOD_PIN_PIN  7
`define RFS_BIT_SYNC_BAD   4
`define RFS_BIT_TSD        3
`define RFS_BIT_TWARN      2
`define RFS_BIT_OVP        1

// converter live status fields
`define RFS_BIT_ONE_EN     7
`define RFS_BIT_ONE_INV    6
`define RFS_BIT_ONE_LIM    4
`define RFS_BIT_ZERO_EN    3
`define RFS_BIT_ZERO_INV   2
`define RFS_BIT_ZERO_LIM   0

// timing
`define RFS_CLK_HZ         50000000
`define RFS_SC_HOLD_US     1000
`define RFS_SC_HOLD_CYCLES ((`RFS_CLK_HZ / 1000000) * `RFS_SC_HOLD_US)

`endif

// ===== core/rfs_top.v
// regulator fault latches and live status registers behind an apb slave
//
// What this block does
// - converter one power-good event sets bit 6
// - converter zero power-good event sets bit 2
// - converter one low over 1 ms sets bit 5
// - converter zero low over 1 ms sets bit 1
// - converter one current limit sets bit 4
// - converter zero current limit sets bit 0
// - linreg one power-good event sets bit 6
// - linreg zero power-good event sets bit 2
// - linreg one low over 1 ms sets bit 5
// - linreg zero low over 1 ms sets bit 1
// - linreg one current limit sets bit 4
// - linreg zero current limit sets bit 0
// - top status bit 7 shows power-good pin
// - top status bit 4 high when sync clock invalid
// - top status bit 3 shows thermal shutdown
// - top status bit 2 shows thermal warning
// - top status bit 1 shows input overvoltage
// - converter summary set while any converter latch set
// - linreg summary set while any linreg latch set
// - converter status shows enable, invalid, current limit
//
// Decided for this implementation: the APB register port.
`include "rfs_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module rfs_top #(
  parameter        SC_HOLD_CYCLES = `RFS_SC_HOLD_CYCLES,
  parameter        CNT_W          = 17
) (
  input  wire        CORE_CLK,
  input  wire        RST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire [1:0]  CONV_PG_EVENT,
  input  wire [1:0]  CONV_OUT_LOW,
  input  wire [1:0]  CONV_ILIM_ACTIVE,
  input  wire [1:0]  CONV_ENABLED,
  input  wire [1:0]  CONV_OUT_INVALID,
  input  wire [1:0]  LINREG_PG_EVENT,
  input  wire [1:0]  LINREG_OUT_LOW,
  input  wire [1:0]  LINREG_ILIM_ACTIVE,
  input  wire        POWER_GOOD_PIN,
  input  wire        SYNC_CLK_INVALID,
  input  wire        THERMAL_SHUTDOWN,
  input  wire        THERMAL_WARNING,
  input  wire        INPUT_OVERVOLTAGE
);

  localparam [CNT_W-1:0] SC_LIMIT = SC_HOLD_CYCLES[CNT_W-1:0];

  // every analog-side condition crosses in through its own two-flop stage
  wire [1:0] conv_pg;
  wire [1:0] conv_low;
  wire [1:0] conv_ilim;
  wire [1:0] conv_en;
  wire [1:0] conv_inv;
  wire [1:0] linreg_pg;
  wire [1:0] linreg_low;
  wire [1:0] linreg_ilim;
  wire       power_good_pin_pin;
  wire       sync_bad;
  wire       tsd;
  wire       twarn;
  wire       ovp;

  rfs_sync2 #(
    .W (2)
  ) u_sync_conv_pg (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (CONV_PG_EVENT),
    .q   (conv_pg)
  );
  rfs_sync2 #(
    .W (2)
  ) u_sync_conv_low (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (CONV_OUT_LOW),
    .q   (conv_low)
  );
  rfs_sync2 #(
    .W (2)
  ) u_sync_conv_ilim (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (CONV_ILIM_ACTIVE),
    .q   (conv_ilim)
  );
  rfs_sync2 #(
    .W (2)
  ) u_sync_conv_en (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (CONV_ENABLED),
    .q   (conv_en)
  );
  rfs_sync2 #(
    .W (2)
  ) u_sync_conv_inv (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (CONV_OUT_INVALID),
    .q   (conv_inv)
  );
  rfs_sync2 #(
    .W (2)
  ) u_sync_linreg_pg (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (LINREG_PG_EVENT),
    .q   (linreg_pg)
  );
  rfs_sync2 #(
    .W (2)
  ) u_sync_linreg_low (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (LINREG_OUT_LOW),
    .q   (linreg_low)
  );
  rfs_sync2 #(
    .W (2)
  ) u_sync_linreg_ilim (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (LINREG_ILIM_ACTIVE),
    .q   (linreg_ilim)
  );
  rfs_sync2 #(
    .W (1)
  ) u_sync_power_good_pin (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (POWER_GOOD_PIN),
    .q   (power_good_pin_pin)
  );
  rfs_sync2 #(
    .W (1)
  ) u_sync_clk_bad (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (SYNC_CLK_INVALID),
    .q   (sync_bad)
  );
  rfs_sync2 #(
    .W (1)
  ) u_sync_tsd (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (THERMAL_SHUTDOWN),
    .q   (tsd)
  );
  rfs_sync2 #(
    .W (1)
  ) u_sync_twarn (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (THERMAL_WARNING),
    .q   (twarn)
  );
  rfs_sync2 #(
    .W (1)
  ) u_sync_ovp (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (INPUT_OVERVOLTAGE),
    .q   (ovp)
  );

  // short-circuit qualifiers: {linreg1, linreg0, conv1, conv0}
  wire [3:0] out_low = {linreg_low, conv_low};
  wire [3:0] sc_hit;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sc
      rfs_low_timer #(
        .CNT_W (CNT_W)
      ) u_low_timer (
        .clk   (CORE_CLK),
        .rst   (RST),
        .low   (out_low[g]),
        .limit (SC_LIMIT),
        .hit   (sc_hit[g])
      );
    end
  endgenerate

  // apb decode
  wire       acc      = PSEL & PENABLE;
  wire       take     = acc & PREADY;
  wire [5:0] idx      = PADDR[7:2];
  wire       aligned  = (PADDR[1:0] == 2'b00);
  wire       hit_sum  = aligned & (idx == `RFS_IDX_TOP_SUMMARY);
  wire       hit_conv = aligned & (idx == `RFS_IDX_CONV_INT_LATCH);
  wire       hit_lin  = aligned & (idx == `RFS_IDX_LINREG_INT_LATCH);
  wire       hit_top  = aligned & (idx == `RFS_IDX_TOP_LIVE_STATUS);
  wire       hit_cst  = aligned & (idx == `RFS_IDX_CONV_LIVE_STATUS);
  wire       mapped   = hit_sum | hit_conv | hit_lin | hit_top | hit_cst;

  reg  [7:0] conv_latch;
  reg  [7:0] linreg_latch;
  reg  [7:0] conv_set;
  reg  [7:0] linreg_set;
  reg  [7:0] conv_clr;
  reg  [7:0] linreg_clr;
  reg  [7:0] next_conv_latch;
  reg  [7:0] next_linreg_latch;

  always @* begin
    conv_set = 8'h00;
    conv_set[`RFS_BIT_ONE_PG]    = conv_pg[1];
    conv_set[`RFS_BIT_ZERO_PG]   = conv_pg[0];
    conv_set[`RFS_BIT_ONE_SC]    = sc_hit[1];
    conv_set[`RFS_BIT_ZERO_SC]   = sc_hit[0];
    conv_set[`RFS_BIT_ONE_ILIM]  = conv_ilim[1];
    conv_set[`RFS_BIT_ZERO_ILIM] = conv_ilim[0];
    linreg_set = 8'h00;
    linreg_set[`RFS_BIT_ONE_PG]    = linreg_pg[1];
    linreg_set[`RFS_BIT_ZERO_PG]   = linreg_pg[0];
    linreg_set[`RFS_BIT_ONE_SC]    = sc_hit[3];
    linreg_set[`RFS_BIT_ZERO_SC]   = sc_hit[2];
    linreg_set[`RFS_BIT_ONE_ILIM]  = linreg_ilim[1];
    linreg_set[`RFS_BIT_ZERO_ILIM] = linreg_ilim[0];
    // write-one-to-clear, only on the completing apb edge
    conv_clr   = (take & PWRITE & hit_conv) ? PWDATA[7:0] : 8'h00;
    linreg_clr = (take & PWRITE & hit_lin)  ? PWDATA[7:0] : 8'h00;
    // set wins over a coincident clear; zeros written leave the bit alone
    next_conv_latch   = ((conv_latch & ~conv_clr) | conv_set)
                        & `RFS_LATCH_MASK;
    next_linreg_latch = ((linreg_latch & ~linreg_clr) | linreg_set)
                        & `RFS_LATCH_MASK;
  end

  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      conv_latch   <= `RFS_LATCH_RESET;
      linreg_latch <= `RFS_LATCH_RESET;
    end else begin
      conv_latch   <= next_conv_latch;
      linreg_latch <= next_linreg_latch;
    end
  end

  // read views
  reg [7:0] sum_view;
  reg [7:0] top_view;
  reg [7:0] cst_view;
  reg [7:0] rd_view;

  always @* begin
    sum_view = 8'h00;
    sum_view[`RFS_BIT_CONV_SUM]   = |conv_latch;
    sum_view[`RFS_BIT_LINREG_SUM] = |linreg_latch;
    top_view = 8'h00;
    top_view[`RFS_BIT_POWER_GOOD_PIN_PIN] = power_good_pin_pin;
    top_view[`RFS_BIT_SYNC_BAD]  = sync_bad;
    top_view[`RFS_BIT_TSD]       = tsd;
    top_view[`RFS_BIT_TWARN]     = twarn;
    top_view[`RFS_BIT_OVP]       = ovp;
    cst_view = 8'h00;
    cst_view[`RFS_BIT_ONE_EN]   = conv_en[1];
    cst_view[`RFS_BIT_ONE_INV]  = conv_inv[1];
    cst_view[`RFS_BIT_ONE_LIM]  = conv_ilim[1];
    cst_view[`RFS_BIT_ZERO_EN]  = conv_en[0];
    cst_view[`RFS_BIT_ZERO_INV] = conv_inv[0];
    cst_view[`RFS_BIT_ZERO_LIM] = conv_ilim[0];
    rd_view = 8'h00;
    if (hit_sum) begin
      rd_view = sum_view;
    end else if (hit_conv) begin
      rd_view = conv_latch;
    end else if (hit_lin) begin
      rd_view = linreg_latch;
    end else if (hit_top) begin
      rd_view = top_view;
    end else if (hit_cst) begin
      rd_view = cst_view;
    end
  end

  // one wait state: pready rises after the first access cycle, data sampled with it
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (acc & !PREADY) begin
      PREADY  <= 1'b1;
      PRDATA  <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_view};
      PSLVERR <= ~mapped;
    end else begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
  end

endmodule // rfs_top

// two-flop synchroniser for levels arriving from outside the clock domain
module rfs_sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] stage_a;
  reg [W-1:0] stage_b;

  // only the second stage feeds logic, so a metastable first stage never spreads
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_a <= {W{1'b0}};
      stage_b <= {W{1'b0}};
    end else begin
      stage_a <= d;
      stage_b <= stage_a;
    end
  end

  assign q = stage_b;

endmodule // rfs_sync2

// counts consecutive low cycles of one regulator output
module rfs_low_timer #(
  parameter CNT_W = 17
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             low,
  input  wire [CNT_W-1:0] limit,
  output reg              hit
);

  reg [CNT_W-1:0] low_cnt;

  // counter stops at the limit, so only a low strictly longer than it fires
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt <= {CNT_W{1'b0}};
      hit     <= 1'b0;
    end else if (!low) begin
      low_cnt <= {CNT_W{1'b0}};
      hit     <= 1'b0;
    end else if (low_cnt < limit) begin
      low_cnt <= low_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      hit     <= 1'b0;
    end else begin
      hit     <= 1'b1;
    end
  end

endmodule // rfs_low_timer

`default_nettype wire

// ===== sim/rfs_properties.sv
// bus timing and reserved-field checks for the fault flag block
`timescale 1ns/10ps
`default_nettype none
module rfs_properties (
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  wire logic rd = PREADY && !PWRITE;
  property p_wait; PSEL && $rose(PENABLE) |=> PREADY; endproperty
  a_wait: assert property (p_wait) else $error("ready late");
  property p_pulse; PREADY |=> !PREADY; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_idle; !PREADY |-> PRDATA == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("data outside answer");
  property p_errq; PSLVERR |-> PREADY; endproperty
  a_errq: assert property (p_errq) else $error("error without ready");
  property p_unal; PREADY && PADDR[1:0] != 2'h0 |-> PSLVERR; endproperty
  a_unal: assert property (p_unal) else $error("unaligned not refused");
  property p_lres; rd && (PADDR == 8'h6c || PADDR == 8'h70) |-> (PRDATA & 32'hffffff88) == 0;
  endproperty
  a_lres: assert property (p_lres) else $error("latch reserved set");
  property p_tres; rd && PADDR == 8'h74 |-> !PSLVERR && (PRDATA & 32'hffffff61) == 0; endproperty
  a_tres: assert property (p_tres) else $error("top status reserved set");
  property p_cres; rd && PADDR == 8'h78 |-> (PRDATA & 32'hffffff22) == 0; endproperty
  a_cres: assert property (p_cres) else $error("conv status reserved set");
  property p_sres; rd && PADDR == 8'h64 |-> (PRDATA & 32'hffffff9f) == 0; endproperty
  a_sres: assert property (p_sres) else $error("summary reserved set");
endmodule // rfs_properties
bind rfs_top rfs_properties u_props (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR));
`default_nettype wire

// ===== sim/rfs_analog_model.sv
// analog detector stand-in: spreads a flat condition word over the raw levels
`timescale 1ns/10ps
`default_nettype none
module rfs_analog_model (
  input  wire logic [20:0] cond,
  output wire logic [1:0]  c_pg,
  output wire logic [1:0]  c_low,
  output wire logic [1:0]  c_ilim,
  output wire logic [1:0]  c_en,
  output wire logic [1:0]  c_inv,
  output wire logic [1:0]  l_pg,
  output wire logic [1:0]  l_low,
  output wire logic [1:0]  l_ilim,
  output wire logic [4:0]  live
);
  // levels only; detector glitches are not modelled
  assign {live, l_ilim, l_low, l_pg, c_inv, c_en, c_ilim, c_low, c_pg} = cond;
endmodule // rfs_analog_model
`default_nettype wire

// ===== sim/rfs_top_test.sv
// self-checking bench for the fault flag block
`timescale 1ns/10ps
`default_nettype none
module rfs_top_test;
  localparam int SC = 20;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [7:0]  paddr = 8'h00, la;
  logic [31:0] pwdata = 32'h0, rdat;
  logic [20:0] cond = 21'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr;
  wire  [1:0]  cpg, clow, cilim, cen, cinv, lpg, llow, lilim;
  wire  [4:0]  live;
  int          err_total = 0, num_checks = 0, cyc = 0;
  int          pos[5] = '{1, 2, 3, 4, 7};
  `define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
  rfs_analog_model u_model (.cond(cond), .c_pg(cpg), .c_low(clow), .c_ilim(cilim),
    .c_en(cen), .c_inv(cinv), .l_pg(lpg), .l_low(llow), .l_ilim(lilim), .live(live));
  rfs_top #(.SC_HOLD_CYCLES(SC)) u_dut (.CORE_CLK(clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CONV_PG_EVENT(cpg), .CONV_OUT_LOW(clow),
    .CONV_ILIM_ACTIVE(cilim), .CONV_ENABLED(cen), .CONV_OUT_INVALID(cinv),
    .LINREG_PG_EVENT(lpg), .LINREG_OUT_LOW(llow), .LINREG_ILIM_ACTIVE(lilim),
    .INPUT_OVERVOLTAGE(live[0]), .THERMAL_WARNING(live[1]), .THERMAL_SHUTDOWN(live[2]),
    .SYNC_CLK_INVALID(live[3]), .POWER_GOOD_PIN(live[4]));
  initial forever #10 clk = ~clk;
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // the wait for ready is bounded only by the cycle ceiling below
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("reg", {25'h0, e}, {er, rdat})
  endtask
  task automatic pulse(input int i, input int n);
    @(posedge clk) cond <= cond | (21'h1 << i);
    repeat (n) @(posedge clk);
    cond <= cond & ~(21'h1 << i);
    repeat (4) @(posedge clk);
  endtask
  // one latch: raise its condition, check set, write-zero keep and write-one clear
  task automatic w1c(input logic [7:0] a, input int i, input int b, input int s);
    pulse(i, 2);
    rd(a, 8'h1 << b);
    rd(8'h64, 8'h1 << s);
    apb(1'b1, a, 32'h0);
    rd(a, 8'h1 << b);
    apb(1'b1, a, 32'hff);
    rd(a, 8'h00);
    rd(8'h64, 8'h00);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(8'h6c, 8'h00);
    rd(8'h70, 8'h00);
    for (int g = 0; g < 2; g++) for (int u = 0; u < 2; u++) begin
      la = g ? 8'h70 : 8'h6c;
      w1c(la, g * 10 + 4 + u, u * 4, g ? 6 : 5);
      w1c(la, g * 10 + u, u * 4 + 2, g ? 6 : 5);
      // exactly the hold count is one short of a fault
      pulse(g * 10 + 2 + u, SC);
      rd(la, 8'h00);
      pulse(g * 10 + 2 + u, SC + 20);
      rd(la, 8'h1 << (u * 4 + 1));
      apb(1'b1, la, 32'hff);
    end
    @(posedge clk) cond[4] <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b1, 8'h6c, 32'h1);
    rd(8'h6c, 8'h01);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) cond <= 21'h1 << (16 + i);
      repeat (4) @(posedge clk);
      rd(8'h74, 8'h1 << pos[i]);
    end
    @(posedge clk) cond <= 21'h1c0;
    apb(1'b1, 8'h74, 32'hff);
    rd(8'h74, 8'h00);
    rd(8'h78, 8'h8c);
    @(posedge clk) cond <= 21'h030;
    repeat (4) @(posedge clk);
    rd(8'h78, 8'h11);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    cond <= 21'h0;
    rd(8'h6c, 8'h00);
    apb(1'b0, 8'h80, 32'h0);
    `CHK("unmapped", 33'h100000000, {er, rdat})
    apb(1'b1, 8'h6d, 32'h0);
    `CHK("unaligned", 1'b1, er)
    results();
  end
endmodule // rfs_top_test
`default_nettype wire
